//--- src/pcc_command_unit.sv
// Card command decoder executing parameter-card codes at drive reset.
`timescale 1ns/10ps
`default_nettype none
module pcc_command_unit (
  // Clock and reset.
  input  wire  logic                  sys_clk,
  input  wire  logic                  reset_n,
  // Avalon-MM register slave.
  input  wire  logic [3:0]            avs_address,
  input  wire  logic                  avs_read,
  input  wire  logic                  avs_write,
  input  wire  logic [31:0]           avs_writedata,
  input  wire  logic [3:0]            avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // Drive identity and card presence.
  input  wire  logic [15:0]           swVersion,
  input  wire  logic                  cardPresent,
  input  wire  logic [9:0]            cardCapacityKb,
  // Card port.
  output pcc_pkg::pcc_cardreq_s       cardReq,
  input  wire  pcc_pkg::pcc_cardrsp_s cardRsp,
  // Drive and keypad indications.
  output logic                        driveTrip,
  output logic                        activityBlink
);
  import pcc_pkg::*;

  // Controller states.
  typedef enum logic [2:0] {
    PCC_IDLE, PCC_DECODE, PCC_ISSUE, PCC_WAIT, PCC_FINISH
  } pcc_state_e;

  // Splits a four-digit code into its leading digit.
  function automatic logic [3:0] leadDigit(input logic [13:0] c);
    leadDigit = 4'(c / 14'd1000);
  endfunction

  // Splits a four-digit code into its three-digit block field.
  function automatic logic [9:0] blockField(input logic [13:0] c);
    blockField = 10'(c % 14'd1000);
  endfunction

  pcc_state_e   state;          // Controller state.
  logic [13:0]  cmdParam;       // Card command parameter.
  logic         roFlag;         // Card read-only flag.
  logic         warnFlag;       // Card warning suppression flag.
  logic         errFlag;        // Last command refused or failed.
  logic         tripFlag;       // Card pulled during a transfer.
  logic         cmpMismatch;    // Last compare found a difference.
  logic         fullFlag;       // Card capacity used up.
  logic         ackPending;     // Bus answer due this cycle.
  logic [31:0]  readData;       // Registered read data.
  logic [23:0]  blinkCount;     // Blink divider count.
  logic         blinkPhase;     // Blink square wave.
  pcc_cardreq_s reqReg;         // Held card request.

  // Decoding of the command parameter.
  wire  [3:0]  digit    = leadDigit(cmdParam);
  wire  [9:0]  blk      = blockField(cmdParam);
  wire         blkOk    = (blk >= PCC_BLK_MIN) && (blk <= PCC_BLK_MAX);
  wire         blkRw    = (blk >= PCC_BLK_MIN) && (blk <= PCC_BLK_RW_MAX);
  wire         isBoot   = (cmdParam == PCC_CODE_BOOT);
  wire         isRoClr  = (cmdParam == PCC_CODE_RCLR);
  wire         isRoSet  = (cmdParam == PCC_CODE_RSET);
  wire         isWClr   = (cmdParam == PCC_CODE_WCLR);
  wire         isWSet   = (cmdParam == PCC_CODE_WSET);
  wire         isErAll  = (cmdParam == PCC_CODE_ERALL);
  wire         warnOk   = (swVersion >= PCC_VER_WARN);
  wire         isLoad   = (digit == 4'd6);
  wire         isWriteOp = isBoot || (digit == 4'd3) || (digit == 4'd4) ||
                           (digit == 4'd5) || (digit == 4'd7);
  // While read only, only loads and the read-only clear act.
  wire         roBlocks = roFlag && !(isLoad || isRoClr);
  // Phase angles are copied on full stores from PCC_VER_PHASE_LO, or on all from PCC_VER_PHASE_ALL.
  wire         phaseAll = (swVersion >= PCC_VER_PHASE_ALL);
  wire         phaseOld = (swVersion >= PCC_VER_PHASE_LO);
  wire         capOk    = (cardCapacityKb >= PCC_CAP_MIN_KB) &&
                          (cardCapacityKb <= PCC_CAP_MAX_KB);
  wire  [19:0] capBytes = 20'(cardCapacityKb * PCC_KB_BYTES);
  wire         cardFull = (cardRsp.bytesUsed >= capBytes);

  // Next request built from the decoded code.
  pcc_cardreq_s nextReq;
  logic         nextLegal;
  always_comb begin
    nextReq           = '0;
    nextLegal         = 1'b0;
    nextReq.block     = blk;
    nextReq.withPhase = phaseAll;
    case (digit)
      4'd2: begin
        if (isBoot) begin
          nextReq.op    = PCC_OP_STORE;
          nextReq.kind  = PCC_KIND_DIFF;
          nextReq.boot  = 1'b1;
          nextReq.block = PCC_BLK_BOOT;
          nextReq.withPhase = phaseAll;
          nextLegal     = 1'b1;
        end
      end
      4'd3: begin
        nextReq.op        = PCC_OP_STORE;
        nextReq.kind      = PCC_KIND_FULL;
        nextReq.withPhase = phaseAll || phaseOld;
        nextLegal         = blkRw;
      end
      4'd4: begin
        nextReq.op   = PCC_OP_STORE;
        nextReq.kind = PCC_KIND_DIFF;
        nextReq.withPhase = phaseAll;
        nextLegal    = blkRw;
      end
      4'd5: begin
        nextReq.op   = PCC_OP_PROG;
        nextReq.kind = PCC_KIND_PROG;
        nextLegal    = blkRw;
      end
      4'd6: begin
        nextReq.op = PCC_OP_LOAD;
        nextLegal  = blkOk;
      end
      4'd7: begin
        nextReq.op = PCC_OP_ERASE;
        nextLegal  = blkRw;
      end
      4'd8: begin
        nextReq.op = PCC_OP_CMP;
        nextLegal  = blkOk;
      end
      4'd9: begin
        if (isErAll) begin
          nextReq.op = PCC_OP_ERALL;
          nextLegal  = 1'b1;
        end
      end
      default: begin
        nextLegal = 1'b0;
      end
    endcase
  end

  // Bus decode.
  wire cmdSel  = (avs_address == PCC_ADDR_CMD);
  wire ctrlSel = (avs_address == PCC_ADDR_CTRL);
  wire wrCmd   = avs_write && cmdSel && avs_byteenable[0] &&
                 avs_byteenable[1] && (state == PCC_IDLE);
  wire rstReq  = avs_write && ctrlSel && avs_byteenable[0] &&
                 avs_writedata[PCC_CT_RESET];
  wire busy    = (state == PCC_ISSUE) || (state == PCC_WAIT);
  wire pulled  = busy && !cardPresent;
  wire [31:0] statusWord = {25'h0, fullFlag, warnFlag, roFlag,
                            cmpMismatch, tripFlag, errFlag, busy};
  wire [31:0] nextRead =
    (avs_address == PCC_ADDR_CMD)    ? {18'h0, cmdParam} :
    (avs_address == PCC_ADDR_STATUS) ? statusWord :
    (avs_address == PCC_ADDR_CAP)    ? {22'h0, cardCapacityKb} :
                                       32'h0000_0000;

  // Every access answers one cycle after it is presented.
  assign avs_waitrequest = (avs_read || avs_write) && !ackPending;
  assign avs_readdata    = readData;
  assign driveTrip       = tripFlag;
  assign activityBlink   = busy && blinkPhase;
  // Request goes out only in the issue state with a card in the slot.
  always_comb begin
    cardReq       = reqReg;
    cardReq.valid = (state == PCC_ISSUE) && cardPresent;
  end

  // Bus answer timing and read data register.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ackPending <= 1'b0;
      readData   <= 32'h0000_0000;
    end else begin
      ackPending <= (avs_read || avs_write) && !ackPending;
      if (avs_read && !ackPending) begin
        readData <= nextRead;
      end
    end
  end

  // Blink divider for the keypad activity indication.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      blinkCount <= 24'h00_0000;
      blinkPhase <= 1'b0;
    end else if (!busy) begin
      blinkCount <= 24'h00_0000;
      blinkPhase <= 1'b1;
    end else if (blinkCount == PCC_BLINK_CNT) begin
      blinkCount <= 24'h00_0000;
      blinkPhase <= !blinkPhase;
    end else begin
      blinkCount <= blinkCount + 24'h00_0001;
    end
  end

  // Command sequencer.  The command is written first and acted on only
  // at a drive reset, so a stray write never starts card traffic.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state       <= PCC_IDLE;
      cmdParam    <= 14'h0000;
      roFlag      <= 1'b0;
      warnFlag    <= 1'b0;
      errFlag     <= 1'b0;
      tripFlag    <= 1'b0;
      cmpMismatch <= 1'b0;
      fullFlag    <= 1'b0;
      reqReg      <= '0;
    end else begin
      case (state)
        PCC_IDLE: begin
          if (wrCmd && ackPending) begin
            cmdParam <= (avs_writedata[13:0] > PCC_CODE_LIMIT) ?
                        14'h0000 : avs_writedata[13:0];
          end
          if (rstReq && ackPending) begin
            tripFlag <= 1'b0;
            state    <= PCC_DECODE;
          end
        end
        PCC_DECODE: begin
          errFlag <= 1'b0;
          state   <= PCC_FINISH;
          if (cmdParam == 14'h0000) begin
            errFlag <= 1'b0;
          end else if (roBlocks) begin
            errFlag <= 1'b0;
          end else if (isRoClr) begin
            roFlag <= 1'b0;
          end else if (isRoSet) begin
            roFlag <= 1'b1;
          end else if (isWClr || isWSet) begin
            if (warnOk) begin
              warnFlag <= isWSet;
            end else begin
              errFlag <= 1'b1;
            end
          end else if (!nextLegal || !cardPresent || !capOk) begin
            errFlag <= 1'b1;
          end else if (isWriteOp && nextReq.op != PCC_OP_ERASE &&
                       fullFlag) begin
            errFlag <= 1'b1;
          end else begin
            reqReg      <= nextReq;
            cmpMismatch <= 1'b0;
            state       <= PCC_ISSUE;
          end
        end
        PCC_ISSUE: begin
          state <= pulled ? PCC_FINISH : PCC_WAIT;
          if (pulled) begin
            tripFlag <= 1'b1;
            errFlag  <= 1'b1;
          end
        end
        PCC_WAIT: begin
          if (pulled) begin
            tripFlag <= 1'b1;
            errFlag  <= 1'b1;
            state    <= PCC_FINISH;
          end else if (cardRsp.done) begin
            errFlag     <= cardRsp.fail;
            cmpMismatch <= (reqReg.op == PCC_OP_CMP) &&
                           cardRsp.mismatch;
            fullFlag    <= cardFull;
            state       <= PCC_FINISH;
          end
        end
        PCC_FINISH: begin
          cmdParam <= 14'h0000;
          state    <= PCC_IDLE;
        end
        default: begin
          state <= PCC_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- src/pcc_pkg.sv
// Package of constants and carrier types for the card command unit.
// Overview of operation
// - Touch card only during a commanded transfer.
// - Card holds 999 numbered block locations.
// - Blocks 1-499 writable, 500-999 read only.
// - Capacity 4kB to 512kB; stop when full.
// - Code written, then drive reset executes it.
// - 2001 stores differences to bootable block 001.
// - 3yyy stores full parameter set to block.
// - 4yyy stores differences-from-default to block.
// - 5yyy stores onboard program to block.
// - 6yyy loads card block into drive.
// - 7yyy erases one block; 9999 erases card.
// - 8yyy compares parameters, changing nothing.
// - 9555 clears, 9666 sets warning suppression.
// - 9777 clears, 9888 sets read-only flag.
// - Block field is 001 to 999.
// - Read-only flag: only 6yyy and 9777 act.
// - Card removed mid-transfer raises a trip.
// - Activity indication while any transfer runs.
// - Newer versions copy both phase angles always.
// - Older versions skip phase angles in diff.
package pcc_pkg;

  // Register byte addresses on the Avalon-MM slave.
  localparam logic [3:0] PCC_ADDR_CMD    = 4'h0;
  localparam logic [3:0] PCC_ADDR_CTRL   = 4'h4;
  localparam logic [3:0] PCC_ADDR_STATUS = 4'h8;
  localparam logic [3:0] PCC_ADDR_CAP    = 4'hC;

  // Block range limits.
  localparam logic [9:0] PCC_BLK_MIN     = 10'd1;
  localparam logic [9:0] PCC_BLK_RW_MAX  = 10'd499;
  localparam logic [9:0] PCC_BLK_MAX     = 10'd999;
  localparam logic [9:0] PCC_BLK_BOOT    = 10'd1;

  // Special whole codes.
  localparam logic [13:0] PCC_CODE_BOOT  = 14'd2001;
  localparam logic [13:0] PCC_CODE_WCLR  = 14'd9555;
  localparam logic [13:0] PCC_CODE_WSET  = 14'd9666;
  localparam logic [13:0] PCC_CODE_RCLR  = 14'd9777;
  localparam logic [13:0] PCC_CODE_RSET  = 14'd9888;
  localparam logic [13:0] PCC_CODE_ERALL = 14'd9999;
  localparam logic [13:0] PCC_CODE_LIMIT = 14'd9999;

  // Capacity in kilobytes, each kilobyte is 1024 bytes.
  localparam logic [9:0]  PCC_CAP_MIN_KB = 10'd4;
  localparam logic [9:0]  PCC_CAP_MAX_KB = 10'd512;
  localparam logic [19:0] PCC_KB_BYTES   = 20'd1024;

  // Software version thresholds, encoded as xx*10000+yy*100+zz.
  localparam logic [15:0] PCC_VER_PHASE_ALL = 16'd10800;
  localparam logic [15:0] PCC_VER_PHASE_LO  = 16'd10500;
  localparam logic [15:0] PCC_VER_WARN      = 16'd10700;
  localparam logic [15:0] PCC_VER_RESET     = 16'd10800;

  // Status bit positions.
  localparam int PCC_ST_BUSY  = 0;
  localparam int PCC_ST_ERR   = 1;
  localparam int PCC_ST_TRIP  = 2;
  localparam int PCC_ST_CMPNE = 3;
  localparam int PCC_ST_RO    = 4;
  localparam int PCC_ST_WARN  = 5;
  localparam int PCC_ST_FULL  = 6;

  // Control bit positions.
  localparam int PCC_CT_RESET = 0;

  // Activity blink divider: 25 MHz down to about 4 Hz toggles.
  localparam int          PCC_CLK_HZ    = 25000000;
  localparam int          PCC_BLINK_HZ  = 4;
  localparam logic [23:0] PCC_BLINK_CNT =
    24'(PCC_CLK_HZ / PCC_BLINK_HZ - 1);

  // Card operations handed to the card port.
  typedef enum logic [2:0] {
    PCC_OP_NONE, PCC_OP_STORE, PCC_OP_LOAD, PCC_OP_PROG,
    PCC_OP_ERASE, PCC_OP_ERALL, PCC_OP_CMP
  } pcc_op_e;

  // Data kind tagged on a card store.
  typedef enum logic [1:0] {
    PCC_KIND_FULL, PCC_KIND_DIFF, PCC_KIND_PROG
  } pcc_kind_e;

  // Request to the card port.
  typedef struct packed {
    logic      valid;
    pcc_op_e   op;
    pcc_kind_e kind;
    logic      boot;
    logic      withPhase;
    logic [9:0] block;
  } pcc_cardreq_s;

  // Answer from the card port.
  typedef struct packed {
    logic done;
    logic fail;
    logic mismatch;
    logic [19:0] bytesUsed;
  } pcc_cardrsp_s;

endpackage

//--- testbench/pcc_command_unit_properties.sv
// Port-level timing and legality checks for the card command unit.
`timescale 1ns/10ps
`default_nettype none
module pcc_command_unit_properties (
  // Clock and reset.
  input wire logic                  sys_clk,
  input wire logic                  reset_n,
  // Register bus.
  input wire logic [3:0]            avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic                  avs_waitrequest,
  // Card side and indications.
  input wire logic [15:0]           swVersion,
  input wire logic                  cardPresent,
  input wire pcc_pkg::pcc_cardreq_s cardReq,
  input wire logic                  driveTrip
);
  import pcc_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // A bus request of either direction is pending.
  wire logic anyReq = avs_read | avs_write;
  // A write to the control register is accepted in this cycle.
  wire logic ctlHit = avs_write & !avs_waitrequest &
                      (avs_address == PCC_ADDR_CTRL);
  // A card request that would change one block of the card, not an erase-all.
  wire logic wrOp = cardReq.valid &
    (cardReq.op inside {PCC_OP_STORE, PCC_OP_PROG, PCC_OP_ERASE});
  // Store request; on newer versions every kind carries withPhase.
  wire logic stOp = cardReq.valid & (cardReq.op == PCC_OP_STORE);

  wait_first_a: assert property (anyReq && !$past(anyReq) |->
    avs_waitrequest) else $error("No wait state on a new request.");
  wait_one_a: assert property (anyReq && avs_waitrequest |=>
    !avs_waitrequest) else $error("Wait state longer than one cycle.");
  pulse_once_a: assert property (cardReq.valid |=> !cardReq.valid)
    else $error("Card request held longer than one cycle.");
  start_cause_a: assert property (cardReq.valid |-> $past(ctlHit, 2))
    else $error("Card request without a drive reset two cycles back.");
  card_idle_a: assert property (cardReq.valid |-> cardPresent)
    else $error("Card addressed while absent.");
  ro_blocks_a: assert property (wrOp |-> cardReq.block >= PCC_BLK_MIN &&
    cardReq.block <= PCC_BLK_RW_MAX) else $error("Write to read-only block.");
  blk_field_a: assert property (cardReq.valid &&
    cardReq.op != PCC_OP_ERALL |-> cardReq.block inside {[1:999]})
    else $error("Block number out of range.");
  boot_blk_a: assert property (cardReq.valid && cardReq.boot |->
    cardReq.block == PCC_BLK_BOOT && cardReq.kind == PCC_KIND_DIFF)
    else $error("Bootable store not a difference set in block one.");
  phase_new_a: assert property (stOp &&
    swVersion >= PCC_VER_PHASE_ALL |-> cardReq.withPhase)
    else $error("Phase angles dropped on a newer version.");
  phase_old_a: assert property (stOp && cardReq.kind == PCC_KIND_DIFF &&
    swVersion < PCC_VER_PHASE_ALL |-> !cardReq.withPhase)
    else $error("Phase angles copied in an older difference set.");
  trip_cause_a: assert property ($rose(driveTrip) |->
    !$past(cardPresent) || !$past(cardPresent, 2))
    else $error("Trip raised while the card stayed present.");
endmodule
bind pcc_command_unit pcc_command_unit_properties u_props (
  .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .swVersion(swVersion),
  .cardPresent(cardPresent), .cardReq(cardReq), .driveTrip(driveTrip));
`default_nettype wire

//--- testbench/pcc_card_model.sv
// Behavioural model of the removable parameter card.
`timescale 1ns/10ps
`default_nettype none
module pcc_card_model (
  // Clock and reset.
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  // Answer delay and compare outcome chosen by the bench.
  input  wire logic [7:0]            rspDelay,
  input  wire logic                  differs,
  // Card port.
  input  wire pcc_pkg::pcc_cardreq_s cardReq,
  output var  pcc_pkg::pcc_cardrsp_s cardRsp
);
  import pcc_pkg::*;
  logic [7:0] waitCnt; // Cycles left before the answer.
  logic       busy;    // A transfer is under way.
  logic       isCmp;   // The transfer is a compare.
  // One transfer at a time; the flags between answers keep changing so
  // that nobody can lean on a stale value.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitCnt <= 8'h00;
      busy <= 1'b0;
      isCmp <= 1'b0;
      cardRsp <= '0;
    end else begin
      cardRsp.done <= 1'b0;
      cardRsp.mismatch <= ~cardRsp.mismatch;
      cardRsp.fail <= ~cardRsp.fail;
      if (cardReq.valid) begin
        busy <= 1'b1;
        waitCnt <= rspDelay;
        isCmp <= (cardReq.op == PCC_OP_CMP);
      end else if (busy && waitCnt == 8'h00) begin
        busy <= 1'b0;
        cardRsp.done <= 1'b1;
        cardRsp.fail <= 1'b0;
        cardRsp.mismatch <= differs & isCmp;
        cardRsp.bytesUsed <= cardRsp.bytesUsed + 20'h0_0040;
      end else if (busy) begin
        waitCnt <= waitCnt - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/pcc_command_unit_tb.sv
// Self-checking bench for the card command unit with a card model.
`timescale 1ns/10ps
`default_nettype none
module pcc_command_unit_tb;
  import pcc_pkg::*;
  logic         sys_clk = 1'b0;
  logic         reset_n = 1'b0;
  logic [3:0]   avs_address = 4'h0;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  logic [31:0]  avs_writedata = 32'h0000_0000;
  logic [3:0]   avs_byteenable = 4'hF;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic [15:0]  swVersion = 16'h2A30;  // Version 10800.
  logic         cardPresent = 1'b1;
  logic [9:0]   cardCapacityKb = 10'h040;
  logic [7:0]   rspDelay = 8'h03;
  logic         differs = 1'b0;
  pcc_cardreq_s cardReq;
  pcc_cardreq_s lastReq;               // Last request seen at the card.
  pcc_cardrsp_s cardRsp;
  logic         driveTrip;
  logic         activityBlink;
  int           reqCount = 0;
  int           bad_count = 0;
  int           samples_checked = 0;
  logic [31:0]  st;
  logic [31:0]  rd;
  always #20 sys_clk = ~sys_clk;
  pcc_command_unit DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .swVersion(swVersion),
    .cardPresent(cardPresent), .cardCapacityKb(cardCapacityKb),
    .cardReq(cardReq), .cardRsp(cardRsp), .driveTrip(driveTrip),
    .activityBlink(activityBlink));
  pcc_card_model card (.sys_clk(sys_clk), .reset_n(reset_n),
    .rspDelay(rspDelay), .differs(differs), .cardReq(cardReq),
    .cardRsp(cardRsp));
  // Capture every request; valid stands for one cycle only.
  always @(posedge sys_clk) begin
    if (cardReq.valid === 1'b1) begin
      lastReq <= cardReq;
      reqCount <= reqCount + 1;
    end
  end
  task automatic end_sim();
    $display("Checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waits for the edge with waitrequest low; a hang ends the run.
  task automatic wait_ack();
    int n;
    n = 0;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 20) begin
      bad_count++;
      end_sim();
    end
  endtask
  // Each access lets one edge pass after release, so strobes never
  // get two assignments in one time step.
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    wait_ack();
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    wait_ack();
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Code, then drive reset, then poll until no longer busy.
  task automatic run_cmd(input logic [31:0] code);
    int n;
    bus_write(PCC_ADDR_CMD, code);
    bus_write(PCC_ADDR_CTRL, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    n = 0;
    st = 32'h0000_0001;
    while (st[PCC_ST_BUSY] !== 1'b0 && n < 100) begin
      bus_read(PCC_ADDR_STATUS, st);
      n++;
    end
    if (n >= 100) begin
      bad_count++;
      end_sim();
    end
  endtask
  task automatic t_codes();
    logic [31:0] codes[7] = '{32'h0000_07D1, 32'h0000_0BBD, 32'h0000_1193,
      32'h0000_139C, 32'h0000_1B57, 32'h0000_1B76, 32'h0000_1F68};
    pcc_op_e ops[7] = '{PCC_OP_STORE, PCC_OP_STORE, PCC_OP_STORE,
      PCC_OP_PROG, PCC_OP_LOAD, PCC_OP_ERASE, PCC_OP_CMP};
    pcc_kind_e kinds[4] = '{PCC_KIND_DIFF, PCC_KIND_FULL, PCC_KIND_DIFF,
      PCC_KIND_PROG};
    logic [9:0] blks[7] = '{10'h001, 10'h005, 10'h1F3, 10'h014, 10'h3E7,
      10'h01E, 10'h028};
    int n0;
    for (int i = 0; i < 8; i++) begin
      n0 = reqCount;
      run_cmd(i == 7 ? 32'h0000_270F : codes[i % 7]);
      check("request count", 32'(reqCount - n0), 32'h0000_0001);
      check("op", 32'(lastReq.op), 32'(i == 7 ? PCC_OP_ERALL : ops[i % 7]));
      if (i < 7) check("block", 32'(lastReq.block), 32'(blks[i]));
      if (i < 4) check("kind", 32'(lastReq.kind), 32'(kinds[i]));
      if (i < 3) check("phase", 32'(lastReq.withPhase), 32'h0000_0001);
      check("boot", 32'(lastReq.boot), 32'(i == 0));
      check("error", 32'(st[PCC_ST_ERR]), 32'h0000_0000);
      bus_read(PCC_ADDR_CMD, rd);
      check("command cleared", rd, 32'h0000_0000);
    end
  endtask
  // Read-only blocks, block zero and a too small card are refused.
  task automatic t_reject();
    logic [31:0] codes[4] = '{32'h0000_0DAC, 32'h0000_0FA0, 32'h0000_1D4C,
      32'h0000_0BBD};
    int n0;
    for (int i = 0; i < 4; i++) begin
      if (i == 3) cardCapacityKb <= 10'h002;
      n0 = reqCount;
      run_cmd(codes[i]);
      check("refused count", 32'(reqCount - n0), 32'h0000_0000);
      check("refused error", 32'(st[PCC_ST_ERR]), 32'h0000_0001);
    end
    bus_read(PCC_ADDR_CAP, rd);
    check("capacity", rd, 32'h0000_0002);
    cardCapacityKb <= 10'h040;
  endtask
  // With the read-only flag set only loads and flag clearing act.
  task automatic t_roflag();
    int n0;
    run_cmd(32'h0000_26A0);
    check("ro set", 32'(st[PCC_ST_RO]), 32'h0000_0001);
    n0 = reqCount;
    run_cmd(32'h0000_0BBD);
    check("ro ignored", 32'(reqCount - n0), 32'h0000_0000);
    run_cmd(32'h0000_1775);
    check("ro load", 32'(reqCount - n0), 32'h0000_0001);
    run_cmd(32'h0000_2631);
    check("ro cleared", 32'(st[PCC_ST_RO]), 32'h0000_0000);
  endtask
  // Warning flag codes, then an older version's phase handling.
  task automatic t_warn();
    run_cmd(32'h0000_25C2);
    check("warn set", 32'(st[PCC_ST_WARN]), 32'h0000_0001);
    run_cmd(32'h0000_2553);
    check("warn clear", 32'(st[PCC_ST_WARN]), 32'h0000_0000);
    swVersion <= 16'h2968;
    run_cmd(32'h0000_25C2);
    check("warn old", 32'(st[PCC_ST_ERR]), 32'h0000_0001);
    run_cmd(32'h0000_0FAA);
    check("diff phase", 32'(lastReq.withPhase), 32'h0000_0000);
    run_cmd(32'h0000_0BC2);
    check("full phase", 32'(lastReq.withPhase), 32'h0000_0001);
    swVersion <= 16'h2A30;
  endtask
  task automatic t_cmp();
    differs <= 1'b1;
    run_cmd(32'h0000_1F68);
    check("compare flag", 32'(st[PCC_ST_CMPNE]), 32'h0000_0001);
    differs <= 1'b0;
    run_cmd(32'h0000_1F68);
    check("compare same", 32'(st[PCC_ST_CMPNE]), 32'h0000_0000);
  endtask
  // Pull the card in mid-transfer against a slow card.
  task automatic t_pull();
    rspDelay <= 8'h28;
    bus_write(PCC_ADDR_CMD, 32'h0000_0BBD);
    bus_write(PCC_ADDR_CTRL, 32'h0000_0001);
    repeat (4) @(posedge sys_clk);
    check("activity", 32'(activityBlink), 32'h0000_0001);
    cardPresent <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check("trip", 32'(driveTrip), 32'h0000_0001);
    bus_read(PCC_ADDR_STATUS, st);
    check("trip status", 32'(st[PCC_ST_TRIP]), 32'h0000_0001);
    check("activity idle", 32'(activityBlink), 32'h0000_0000);
    cardPresent <= 1'b1;
    repeat (60) @(posedge sys_clk);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    bus_read(PCC_ADDR_STATUS, st);
    check("status reset", st, 32'h0000_0000);
    check("no request", 32'(cardReq.valid), 32'h0000_0000);
    t_codes();
    t_reject();
    t_roflag();
    t_warn();
    t_cmp();
    t_pull();
    end_sim();
  end
endmodule
`default_nettype wire
